// >>> bench/tcm_partner.sv
// safety interlock and supervising controller model
`timescale 1ns/1ps
module tcm_partner
(
   // clock
   input  wire logic       clk,
   // bench requests: ch1, ch2, err1, err2, run, reset
   input  wire logic [5:0] req,
   input  wire logic       restart_permit,
   // pins toward the drive
   output logic      [5:0] pins
);
   initial pins = 6'h03;
   always @(posedge clk)
   begin
      pins[3:0] <= req[3:0];
      pins[5] <= req[5];
      // a start needs the permit, a stop is always allowed
      pins[4] <= req[4] & (pins[4] | restart_permit);
   end
endmodule

// >>> bench/testbench.sv
// self-checking bench for the torque cut monitor
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [5:0]  req = 6'h03;
   logic [5:0]  pins;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] rdata;
   logic [15:0] rv;
   logic        te;
   logic        disp;
   logic        permit;
   logic        irq;
   logic [7:0]  code;
   logic [5:0]  term;
   int          mismatches = 0;
   int          checks = 0;
   logic [5:0]  fv [5] = '{6'h11, 6'h12, 6'h17, 6'h1b, 6'h1f};
   logic [7:0]  fc [5] = '{8'h4d, 8'h48, 8'h48, 8'h4d, 8'h4e};

   always #50 clk = ~clk;

   tcm_partner tcm_partner_i
   (
      .clk(clk), .req(req), .restart_permit(permit), .pins(pins)
   );
   tcm_monitor tcm_monitor_i
   (
      .clk(clk), .rst_b(rst_b), .ce(1'b1),
      .safety_channel_one_in(pins[0]), .safety_channel_two_in(pins[1]),
      .chan_one_circuit_err(pins[2]), .chan_two_circuit_err(pins[3]),
      .run_cmd_in(pins[4]), .reset_cmd_in(pins[5]),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .torque_enable(te), .torque_cut_display(disp),
      .restart_permit(permit), .fault_code(code),
      .relay_one_contact(term[0]), .relay_two_contact(term[1]),
      .relay_three_contact(term[2]), .relay_four_contact(term[3]),
      .open_collector_one(term[4]), .open_collector_two(term[5]),
      .irq(irq)
   );

   task automatic chk(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bw(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic br(input logic [3:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   // pins need one partner edge plus four design edges
   task automatic pin(input logic [5:0] v);
      @(posedge clk);
      req <= v;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic st(input logic [3:0] e);
      br(tcm_pkg::REG_STATUS);
      chk("status", {12'h000, rv[3:0]}, {12'h000, e});
   endtask
   task automatic clr();
      bw(tcm_pkg::REG_CMD, 16'h0001);
      pin(req);
      pin(req);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic t_regs();
      br(tcm_pkg::REG_POL_MASK);
      chk("pol", rv, 16'h0000);
      br(tcm_pkg::REG_LATCH_SEL);
      chk("latch", rv, 16'h0000);
      br(tcm_pkg::REG_FUNC_BASE + 4'h4);
      chk("fn5", rv, 16'h002a);
      br(4'hf);
      chk("unmapped", rv, 16'h0000);
      $display("test regs done");
   endtask
   task automatic t_run();
      pin(6'h13);
      chk("run te", {15'h0, te}, 16'h0001);
      chk("oc1 open", {15'h0, term[4]}, 16'h0000);
      pin(6'h03);
      chk("stop te", {15'h0, te}, 16'h0000);
      pin(6'h13);
      $display("test run done");
   endtask
   task automatic t_cut();
      bw(tcm_pkg::REG_IRQ_MASK, 16'h0001);
      pin(6'h10);
      chk("cut te", {15'h0, te}, 16'h0000);
      chk("display", {15'h0, disp}, 16'h0001);
      chk("code", {8'h0, code}, 16'h004c);
      chk("oc1 closed", {15'h0, term[4]}, 16'h0001);
      chk("irq", {15'h0, irq}, 16'h0001);
      st(4'hb);
      pin(6'h30);
      pin(6'h03);
      st(4'h8);
      pin(6'h13);
      chk("no start", {15'h0, pins[4]}, 16'h0000);
      clr();
      st(4'h0);
      bw(tcm_pkg::REG_IRQ_STAT, 16'h000f);
      pin(req);
      chk("irq clr", {15'h0, irq}, 16'h0000);
      $display("test cut done");
   endtask
   task automatic t_nolatch();
      bw(tcm_pkg::REG_IRQ_MASK, 16'h0000);
      bw(tcm_pkg::REG_LATCH_SEL, 16'h0001);
      pin(6'h10);
      chk("code sel1", {8'h0, code}, 16'h0000);
      chk("irq masked", {15'h0, irq}, 16'h0000);
      pin(6'h13);
      st(4'h0);
      bw(tcm_pkg::REG_LATCH_SEL, 16'h0000);
      $display("test nolatch done");
   endtask
   task automatic t_fault();
      // self clearing select must not release a channel fault alarm
      bw(tcm_pkg::REG_LATCH_SEL, 16'h0001);
      for (int i = 0; i < 5; i++)
      begin
         pin(fv[i]);
         chk("fault code", {8'h0, code}, {8'h0, fc[i]});
         chk("fault te", {15'h0, te}, 16'h0000);
         bw(tcm_pkg::REG_LATCH_SEL, 16'h0000);
         br(tcm_pkg::REG_LATCH_SEL);
         chk("locked", rv, 16'h0001);
         pin(6'h13);
         st(4'h8);
         clr();
      end
      bw(tcm_pkg::REG_LATCH_SEL, 16'h0000);
      $display("test fault done");
   endtask
   task automatic t_pol();
      bw(tcm_pkg::REG_POL_MASK, 16'h0010);
      br(tcm_pkg::REG_POL_MASK);
      chk("pol rd", rv, 16'h0010);
      pin(req);
      chk("logic b ok", {15'h0, term[4]}, 16'h0001);
      pin(6'h10);
      chk("logic b cut", {15'h0, term[4]}, 16'h0000);
      pin(6'h13);
      clr();
      bw(tcm_pkg::REG_POL_MASK, 16'h003f);
      pin(req);
      chk("all inv", {10'h0, term}, 16'h003d);
      $display("test pol done");
   endtask

   initial
   begin
      #2000000;
      mismatches++;
      final_report();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_run();
      t_cut();
      t_nolatch();
      t_fault();
      t_pol();
      final_report();
   end
endmodule

// >>> design/tcm_irq.sv
// sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
module tcm_irq
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic ce,
   // core side
   tcm_irq_if.irqc   bus
);
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         bus.stat <= tcm_pkg::IRQ_RST;
      else if (ce)
      begin
         // a new event outweighs a clear in the same cycle
         if (bus.stat_wr)
            bus.stat <= (bus.stat & ~bus.wdata) | bus.evt;
         else
            bus.stat <= bus.stat | bus.evt;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         bus.mask <= tcm_pkg::IRQ_RST;
      else if (ce && bus.mask_wr)
         bus.mask <= bus.wdata;
   end

   // one cycle behind status, kept registered for a clean output
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         bus.irq <= 1'b0;
      else if (ce)
         bus.irq <= |(bus.stat & bus.mask);
   end
endmodule

// >>> design/tcm_monitor.sv
// dual channel torque cut monitor: mode decode, alarm, outputs, registers
`timescale 1ns/1ps
module tcm_monitor
(
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // safety interlock pins
   input  wire logic        safety_channel_one_in,
   input  wire logic        safety_channel_two_in,
   input  wire logic        chan_one_circuit_err,
   input  wire logic        chan_two_circuit_err,
   // controller pins
   input  wire logic        run_cmd_in,
   input  wire logic        reset_cmd_in,
   // register port
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   // drive status
   output logic             torque_enable,
   output logic             torque_cut_display,
   output logic             restart_permit,
   output logic      [7:0]  fault_code,
   // output terminals
   output logic             relay_one_contact,
   output logic             relay_two_contact,
   output logic             relay_three_contact,
   output logic             relay_four_contact,
   output logic             open_collector_one,
   output logic             open_collector_two,
   // interrupt
   output logic             irq
);
   tcm_irq_if irq_bus ();

   logic [5:0]          s;
   tcm_pkg::tcm_mode_e  mode_reg;
   tcm_pkg::tcm_mode_e  mode_next;
   logic                alarm_reg;
   logic                alarm_fault_reg;
   logic [1:0]          latch_sel_reg;
   logic [11:0]         pol_reg;
   logic [7:0]          func_reg [tcm_pkg::N_TERM];
   logic [5:0]          term_reg;
   logic                reset_prev_reg;
   logic [1:0]          prime_reg;
   logic                reset_req;
   logic                chan_fault;
   logic                chan_fault_next;
   logic                safety_act;
   logic                alarm_clr;
   logic                sel_wr_ok;
   logic [15:0]         rdata_next;

   tcm_sync #(.W(tcm_pkg::SYNC_W)) u_sync
   (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .d     ({reset_cmd_in, run_cmd_in, chan_two_circuit_err,
               chan_one_circuit_err, safety_channel_two_in,
               safety_channel_one_in}),
      .q     (s)
   );

   tcm_irq u_irq
   (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .bus   (irq_bus)
   );

   function automatic logic is_chan_fault(input tcm_pkg::tcm_mode_e m);
      return m == tcm_pkg::MODE_CH1_FAULT || m == tcm_pkg::MODE_CH2_FAULT ||
             m == tcm_pkg::MODE_DUAL_FAULT;
   endfunction

   // level that a terminal function asks for, before polarity
   function automatic logic term_level(input logic [7:0] fn,
                                       input logic       act,
                                       input logic       run,
                                       input logic       alarm);
      logic lvl;
      lvl = 1'b0;
      if (fn == tcm_pkg::FN_SAFETY)
         lvl = act;
      else if (fn == tcm_pkg::FN_RUN)
         lvl = run;
      else if (fn == tcm_pkg::FN_FAULT)
         lvl = alarm;
      return lvl;
   endfunction

   // circuit errors outrank the input decode
   always_comb
   begin
      if (s[tcm_pkg::S_ERR1] && s[tcm_pkg::S_ERR2])
         mode_next = tcm_pkg::MODE_DUAL_FAULT;
      else if (s[tcm_pkg::S_ERR1])
         mode_next = tcm_pkg::MODE_CH1_FAULT;
      else if (s[tcm_pkg::S_ERR2])
         mode_next = tcm_pkg::MODE_CH2_FAULT;
      else
      begin
         unique case ({s[tcm_pkg::S_CH1], s[tcm_pkg::S_CH2]})
            2'b11: mode_next = tcm_pkg::MODE_READY;
            2'b10: mode_next = tcm_pkg::MODE_CH2_FAULT;
            2'b01: mode_next = tcm_pkg::MODE_CH1_FAULT;
            2'b00: mode_next = tcm_pkg::MODE_TORQUE_CUT;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_reg  <= tcm_pkg::MODE_READY;
         prime_reg <= '0;
      end
      else if (ce)
      begin
         prime_reg <= {prime_reg[0], 1'b1};
         // synchroniser still shows its reset zeros for two edges,
         // which would decode as a false torque cut and latch an alarm
         if (prime_reg[1])
            mode_reg <= mode_next;
      end
   end

   assign chan_fault      = is_chan_fault(mode_reg);
   assign chan_fault_next = is_chan_fault(mode_next);
   assign safety_act      = mode_reg != tcm_pkg::MODE_READY;
   assign reset_req = (s[tcm_pkg::S_RESET] && !reset_prev_reg) ||
                      (wr && addr == tcm_pkg::REG_CMD &&
                       wdata[tcm_pkg::CMD_RESET_BIT]);
   // only a ready drive may drop its alarm
   assign alarm_clr = alarm_reg && !safety_act &&
                      ((!alarm_fault_reg &&
                        latch_sel_reg == tcm_pkg::LATCH_OFF) ||
                       reset_req);
   assign sel_wr_ok = !chan_fault && !alarm_fault_reg;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         reset_prev_reg <= 1'b0;
      else if (ce)
         reset_prev_reg <= s[tcm_pkg::S_RESET];
   end

   // alarm: set by any non-ready mode, cleared per latch policy
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         alarm_reg       <= 1'b0;
         alarm_fault_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (safety_act)
         begin
            alarm_reg       <= 1'b1;
            alarm_fault_reg <= alarm_fault_reg | chan_fault;
         end
         else if (alarm_clr)
         begin
            alarm_reg       <= 1'b0;
            alarm_fault_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         fault_code <= tcm_pkg::FC_NONE;
      else if (ce)
      begin
         unique case (mode_reg)
            tcm_pkg::MODE_CH1_FAULT:  fault_code <= tcm_pkg::FC_CH1;
            tcm_pkg::MODE_CH2_FAULT:  fault_code <= tcm_pkg::FC_CH2;
            tcm_pkg::MODE_DUAL_FAULT: fault_code <= tcm_pkg::FC_DUAL;
            tcm_pkg::MODE_TORQUE_CUT:
               fault_code <= (latch_sel_reg == tcm_pkg::LATCH_OFF) ?
                             tcm_pkg::FC_NONE : tcm_pkg::FC_TCUT;
            tcm_pkg::MODE_READY:
               if (alarm_clr)
                  fault_code <= tcm_pkg::FC_NONE;
         endcase
      end
   end

   // drive status outputs
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         torque_enable      <= 1'b0;
         torque_cut_display <= 1'b0;
         restart_permit     <= 1'b0;
      end
      else if (ce)
      begin
         // a latched alarm keeps torque off even when ready
         torque_enable      <= !safety_act && !alarm_reg &&
                               s[tcm_pkg::S_RUN];
         torque_cut_display <= mode_reg == tcm_pkg::MODE_TORQUE_CUT;
         restart_permit     <= !safety_act && !alarm_reg;
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         latch_sel_reg <= tcm_pkg::LATCH_SEL_RST;
         pol_reg       <= tcm_pkg::POL_RST;
         for (int i = 0; i < tcm_pkg::N_TERM; i++)
            func_reg[i] <= tcm_pkg::FN_RST[i];
      end
      else if (ce && wr)
      begin
         if (addr == tcm_pkg::REG_LATCH_SEL && sel_wr_ok)
            latch_sel_reg <= wdata[1:0];
         if (addr == tcm_pkg::REG_POL_MASK)
            pol_reg <= wdata[tcm_pkg::POL_W-1:0];
         for (int i = 0; i < tcm_pkg::N_TERM; i++)
            if (addr == tcm_pkg::REG_FUNC_BASE + 4'(i))
               func_reg[i] <= wdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         term_reg <= '0;
      else if (ce)
         for (int i = 0; i < tcm_pkg::N_TERM; i++)
            term_reg[i] <= term_level(func_reg[i], safety_act,
                                      !safety_act && !alarm_reg &&
                                      s[tcm_pkg::S_RUN],
                                      alarm_reg | safety_act) ^
                           pol_reg[i];
   end

   assign relay_one_contact   = term_reg[0];
   assign relay_two_contact   = term_reg[1];
   assign relay_three_contact = term_reg[2];
   assign relay_four_contact  = term_reg[3];
   assign open_collector_one  = term_reg[4];
   assign open_collector_two  = term_reg[5];

   // interrupt events and register access
   assign irq_bus.evt[tcm_pkg::IRQ_ALARM]   = safety_act && !alarm_reg;
   assign irq_bus.evt[tcm_pkg::IRQ_TCUT]    =
      mode_next == tcm_pkg::MODE_TORQUE_CUT &&
      mode_reg != tcm_pkg::MODE_TORQUE_CUT;
   assign irq_bus.evt[tcm_pkg::IRQ_CHFAULT] = chan_fault_next && !chan_fault;
   assign irq_bus.evt[tcm_pkg::IRQ_CLEAR]   = alarm_clr;
   assign irq_bus.stat_wr = wr && addr == tcm_pkg::REG_IRQ_STAT;
   assign irq_bus.mask_wr = wr && addr == tcm_pkg::REG_IRQ_MASK;
   assign irq_bus.wdata   = wdata[tcm_pkg::IRQ_W-1:0];
   assign irq             = irq_bus.irq;

   always_comb
   begin
      rdata_next = '0;
      if (addr == tcm_pkg::REG_LATCH_SEL)
         rdata_next[1:0] = latch_sel_reg;
      else if (addr == tcm_pkg::REG_POL_MASK)
         rdata_next[tcm_pkg::POL_W-1:0] = pol_reg;
      else if (addr >= tcm_pkg::REG_FUNC_BASE && addr < tcm_pkg::REG_STATUS)
         rdata_next[7:0] = func_reg[3'(addr - tcm_pkg::REG_FUNC_BASE)];
      else if (addr == tcm_pkg::REG_STATUS)
      begin
         rdata_next[tcm_pkg::ST_MODE_LSB +: 3] = mode_reg;
         rdata_next[tcm_pkg::ST_ALARM]         = alarm_reg;
         rdata_next[tcm_pkg::ST_DRIVE]         = torque_enable;
         rdata_next[tcm_pkg::ST_PERMIT]        = restart_permit;
         rdata_next[tcm_pkg::ST_CODE_LSB +: 8] = fault_code;
      end
      else if (addr == tcm_pkg::REG_IRQ_STAT)
         rdata_next[tcm_pkg::IRQ_W-1:0] = irq_bus.stat;
      else if (addr == tcm_pkg::REG_IRQ_MASK)
         rdata_next[tcm_pkg::IRQ_W-1:0] = irq_bus.mask;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rdata <= '0;
      else if (ce && rd)
         rdata <= rdata_next;
      else if (ce)
         rdata <= '0;
   end

   default clocking cb @(posedge clk iff ce);
   endclocking
   default disable iff (!rst_b);

   chk_mode_decode: assert property (
      (s[tcm_pkg::S_CH1] && !s[tcm_pkg::S_CH2] && !s[tcm_pkg::S_ERR1] &&
       !s[tcm_pkg::S_ERR2]) |=> mode_reg == tcm_pkg::MODE_CH2_FAULT)
      else $error("channel two low not decoded as its fault mode");
   chk_nonready_stop: assert property (
      safety_act |=> !torque_enable ##1 !torque_enable || !$past(safety_act))
      else $error("torque enabled outside ready mode");
   chk_run_follow: assert property (
      (!safety_act && !alarm_reg) |=>
      torque_enable == $past(s[tcm_pkg::S_RUN]))
      else $error("torque enable does not follow run command");
   chk_tcut_stop: assert property (
      mode_reg == tcm_pkg::MODE_TORQUE_CUT |=>
      !torque_enable && torque_cut_display && alarm_reg)
      else $error("torque cut did not stop output and show display");
   chk_latch_hold: assert property (
      (alarm_reg && !safety_act && latch_sel_reg != tcm_pkg::LATCH_OFF &&
       !reset_req) |=> alarm_reg)
      else $error("latched alarm dropped without reset");
   chk_latch_off: assert property (
      (alarm_reg && !alarm_fault_reg && !safety_act &&
       latch_sel_reg == tcm_pkg::LATCH_OFF) |=> !alarm_reg && !restart_permit
      ##1 restart_permit || safety_act || alarm_reg)
      else $error("unlatched alarm did not clear itself");
   chk_fault_latch: assert property (
      (alarm_fault_reg && !safety_act && !reset_req) |=> alarm_reg)
      else $error("channel fault alarm cleared without reset");
   chk_sel_lock: assert property (
      (wr && addr == tcm_pkg::REG_LATCH_SEL && chan_fault) |=>
      $stable(latch_sel_reg))
      else $error("latch select written during channel fault");
   chk_code_chan: assert property (
      mode_reg == tcm_pkg::MODE_CH1_FAULT |=> fault_code == tcm_pkg::FC_CH1)
      else $error("channel one fault code wrong");
   chk_code_tcut: assert property (
      (mode_reg == tcm_pkg::MODE_TORQUE_CUT &&
       latch_sel_reg != tcm_pkg::LATCH_OFF) |=> fault_code == tcm_pkg::FC_TCUT)
      else $error("torque cut fault code wrong");
   chk_code_dual: assert property (
      (s[tcm_pkg::S_ERR1] && s[tcm_pkg::S_ERR2]) |=> ##1
      fault_code == tcm_pkg::FC_DUAL)
      else $error("dual channel fault code wrong");
   chk_safety_term: assert property (
      func_reg[tcm_pkg::TERM_OC_ONE] == tcm_pkg::FN_SAFETY |=>
      open_collector_one == ($past(safety_act) ^ $past(pol_reg[4])))
      else $error("safety status terminal level wrong");
   chk_reset_gate: assert property (
      (reset_req && safety_act) |=> alarm_reg)
      else $error("reset cleared alarm with a channel low");

   cov_tcut_entry: cover property (
      mode_reg == tcm_pkg::MODE_READY ##1
      mode_reg == tcm_pkg::MODE_TORQUE_CUT);
   cov_reset_clear: cover property (
      alarm_reg && !safety_act && reset_req ##1 !alarm_reg);
   cov_logic_b: cover property (pol_reg == 12'h010 && safety_act);
   cov_dual: cover property (mode_reg == tcm_pkg::MODE_DUAL_FAULT);
endmodule

// >>> design/tcm_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module tcm_sync #(
   parameter int W = 6
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   // lanes
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else if (ce)
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// >>> shared/tcm_irq_if.sv
// event, status and mask signals between monitor core and interrupt block
`timescale 1ns/1ps
interface tcm_irq_if;
   logic [3:0] evt;
   logic       stat_wr;
   logic       mask_wr;
   logic [3:0] wdata;
   logic [3:0] stat;
   logic [3:0] mask;
   logic       irq;

   modport core
   (
      output evt,
      output stat_wr,
      output mask_wr,
      output wdata,
      input  stat,
      input  mask,
      input  irq
   );
   modport irqc
   (
      input  evt,
      input  stat_wr,
      input  mask_wr,
      input  wdata,
      output stat,
      output mask,
      output irq
   );
endinterface

// >>> shared/tcm_pkg.sv
// constants, register map and mode type of the torque cut monitor
package tcm_pkg;
   // register bus
   localparam int         ADDR_W         = 4;
   localparam int         DATA_W         = 16;
   localparam logic [3:0] REG_LATCH_SEL  = 4'h0;
   localparam logic [3:0] REG_POL_MASK   = 4'h1;
   localparam logic [3:0] REG_FUNC_BASE  = 4'h2;
   localparam logic [3:0] REG_STATUS     = 4'h8;
   localparam logic [3:0] REG_IRQ_STAT   = 4'h9;
   localparam logic [3:0] REG_IRQ_MASK   = 4'ha;
   localparam logic [3:0] REG_CMD        = 4'hb;
   localparam int         CMD_RESET_BIT  = 0;
   // alarm latch select
   localparam logic [1:0] LATCH_OFF      = 2'h1;
   localparam logic [1:0] LATCH_SEL_RST  = 2'h0;
   // output terminals: relays one to four, open collectors one and two
   localparam int         N_TERM         = 6;
   localparam int         TERM_OC_ONE    = 4;
   localparam int         POL_W          = 12;
   localparam logic [11:0] POL_RST       = 12'h000;
   localparam logic [7:0] FN_NONE        = 8'h00;
   localparam logic [7:0] FN_RUN         = 8'h01;
   localparam logic [7:0] FN_FAULT       = 8'h02;
   localparam logic [7:0] FN_SAFETY      = 8'h2a;
   localparam logic [7:0] FN_RST [N_TERM] =
      '{8'h0b, 8'h01, 8'h00, 8'h00, 8'h2a, 8'h00};
   // fault codes
   localparam logic [7:0] FC_NONE        = 8'h00;
   localparam logic [7:0] FC_CH1         = 8'h48;
   localparam logic [7:0] FC_TCUT        = 8'h4c;
   localparam logic [7:0] FC_CH2         = 8'h4d;
   localparam logic [7:0] FC_DUAL        = 8'h4e;
   // status register fields
   localparam int         ST_MODE_LSB    = 0;
   localparam int         ST_ALARM       = 3;
   localparam int         ST_DRIVE       = 4;
   localparam int         ST_PERMIT      = 5;
   localparam int         ST_CODE_LSB    = 8;
   // interrupt events
   localparam int         IRQ_W          = 4;
   localparam int         IRQ_ALARM      = 0;
   localparam int         IRQ_TCUT       = 1;
   localparam int         IRQ_CHFAULT    = 2;
   localparam int         IRQ_CLEAR      = 3;
   localparam logic [3:0] IRQ_RST        = 4'h0;
   // pin synchroniser lanes
   localparam int         SYNC_W         = 6;
   localparam int         S_CH1          = 0;
   localparam int         S_CH2          = 1;
   localparam int         S_ERR1         = 2;
   localparam int         S_ERR2         = 3;
   localparam int         S_RUN          = 4;
   localparam int         S_RESET        = 5;

   typedef enum logic [2:0]
   {
      MODE_READY,
      MODE_CH1_FAULT,
      MODE_CH2_FAULT,
      MODE_TORQUE_CUT,
      MODE_DUAL_FAULT
   } tcm_mode_e;
endpackage
